// ===== core/ssr_defs.svh
// constants of the clocked serial port: register offsets, bit positions, reset values
// assumes a 32-bit Avalon-MM slave with byte addresses, one aligned word per register
// Behaviour
// - either receive enable starts master reception
// - sample data on falling shift clock edges
// - single-word enable receives one word, stops
// - continuous enable receives until software clears it
// - both enables set behaves as continuous
// - word done sets flag, irq if enabled
// - clearing continuous enable clears receive errors
// - nine-bit select puts ninth bit in status
// - slave mode never drives the shift clock
// - clock source select cleared means slave mode
// - slave shifting runs from external clock edges
// - first written word moves to shift register
// - second word waits, empty flag stays clear
// - after shift out, reload then set flag
// - empty flag with enable raises wake request
// - nine-bit transmit sends preloaded ninth bit
// - holding write with enable starts transmission
// - half duplex, transmit and receive exclude
// - empty flag clears only on holding write
// - clock source set drives the shift clock
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define SSR_OFF_RX_STAT 5'h00
`define SSR_OFF_RX_BUF 5'h04
`define SSR_OFF_TX_STAT 5'h08
`define SSR_OFF_BAUD 5'h0C
`define SSR_OFF_TX_HOLD 5'h10
`define SSR_OFF_IRQ_EN 5'h14
`define SSR_OFF_FLAGS 5'h18
// ****************************************************************
// field positions
// ****************************************************************
`define SSR_RX_PORT_EN 7
`define SSR_RX_NINE 6
`define SSR_RX_SINGLE 5
`define SSR_RX_CONT 4
`define SSR_RX_ADDR_DET 3
`define SSR_TX_CLK_SRC 7
`define SSR_TX_NINE 6
`define SSR_TX_EN 5
`define SSR_TX_CLOCKED 4
`define SSR_TX_HIGH_BAUD 2
`define SSR_TX_NINTH 0
`define SSR_IE_RX 0
`define SSR_IE_TX 1
// ****************************************************************
// reset values and counts
// ****************************************************************
`define SSR_TX_STAT_RESET 8'h02
`define SSR_BITS8 4'h8
`define SSR_BITS9 4'h9
`endif

// ===== core/ssr_pkg.sv
// types of the clocked serial port
// assumes ssr_defs.svh for the numbers
`default_nettype none
package ssr_pkg;
  typedef struct packed {
    logic port_enable;
    logic receive_nine_bit_select;
    logic single_word_receive_enable;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic framing_error_flag;
    logic overrun_error_flag;
    logic receive_ninth_data;
    logic clock_source_select;
    logic transmit_nine_bit_select;
    logic transmit_enable;
    logic clocked_mode_select;
    logic high_baud_select;
    logic transmit_ninth_data;
    logic [7:0] baud_divisor;
    logic [7:0] transmit_holding;
    logic hold_full;
    logic [8:0] transmit_shift_register;
    logic [3:0] tx_cnt;
    logic tx_busy;
    logic [8:0] rx_shift;
    logic [3:0] rx_cnt;
    logic rx_busy;
    logic [7:0] receive_buffer;
    logic receive_done_flag;
    logic transmit_buffer_empty_flag;
    logic receive_irq_enable;
    logic transmit_irq_enable;
    logic [7:0] baud_cnt;
    logic sck;
    logic sck_oe;
    logic dout;
    logic dout_oe;
    logic ck_s1;
    logic ck_s2;
    logic ck_s3;
    logic dt_s1;
    logic dt_s2;
    logic wait_r;
    logic [7:0] rdata;
    logic irq;
  } ssr_state_type;
endpackage : ssr_pkg
`default_nettype wire

// ===== core/ssr_top.sv
// clocked half-duplex serial port: master reception, transmission in master or slave mode
// assumes an Avalon-MM master on clk and a peer on the clock and data pins
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defs.svh"
module ssr_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe,
  output logic irq_wake
);
  import ssr_pkg::*;

  ssr_pkg::ssr_state_type st_r;
  ssr_pkg::ssr_state_type st_nxt;
  logic rd_take;
  logic wr_take;
  logic wr_hold;
  logic active;
  logic term;
  logic sck_fall;
  logic ext_fall;
  logic tx_done;
  logic rx_done;
  logic rx_start;
  logic tx_load;
  logic [3:0] tx_bits;
  logic [3:0] rx_bits;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    rd_take = avs_read && !st_r.wait_r;
    wr_take = avs_write && !st_r.wait_r && avs_byteenable[0];
    wr_hold = wr_take && (avs_address == `SSR_OFF_TX_HOLD);
    active = st_r.port_enable && st_r.clocked_mode_select;
    tx_bits = st_r.transmit_nine_bit_select ? `SSR_BITS9 : `SSR_BITS8;
    rx_bits = st_r.receive_nine_bit_select ? `SSR_BITS9 : `SSR_BITS8;
    term = 1'b0;
    tx_done = 1'b0;
    rx_done = 1'b0;
    // one wait cycle per access, released for the cycle in which the request is taken
    st_nxt.wait_r = !((avs_read || avs_write) && st_r.wait_r);
    if (avs_read && st_r.wait_r) begin
      if (avs_address == `SSR_OFF_RX_STAT) begin
        st_nxt.rdata = {st_r.port_enable, st_r.receive_nine_bit_select,
          st_r.single_word_receive_enable, st_r.continuous_receive_enable,
          st_r.address_detect_enable, st_r.framing_error_flag,
          st_r.overrun_error_flag, st_r.receive_ninth_data};
      end else if (avs_address == `SSR_OFF_RX_BUF) begin
        st_nxt.rdata = st_r.receive_buffer;
      end else if (avs_address == `SSR_OFF_TX_STAT) begin
        st_nxt.rdata = {st_r.clock_source_select, st_r.transmit_nine_bit_select,
          st_r.transmit_enable, st_r.clocked_mode_select, 1'b0, st_r.high_baud_select,
          !st_r.tx_busy, st_r.transmit_ninth_data};
      end else if (avs_address == `SSR_OFF_BAUD) begin
        st_nxt.rdata = st_r.baud_divisor;
      end else if (avs_address == `SSR_OFF_TX_HOLD) begin
        st_nxt.rdata = st_r.transmit_holding;
      end else if (avs_address == `SSR_OFF_IRQ_EN) begin
        st_nxt.rdata = {6'h00, st_r.transmit_irq_enable, st_r.receive_irq_enable};
      end else if (avs_address == `SSR_OFF_FLAGS) begin
        st_nxt.rdata = {6'h00, st_r.transmit_buffer_empty_flag, st_r.receive_done_flag};
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
    // register writes
    if (wr_take) begin
      if (avs_address == `SSR_OFF_RX_STAT) begin
        st_nxt.port_enable = avs_writedata[`SSR_RX_PORT_EN];
        st_nxt.receive_nine_bit_select = avs_writedata[`SSR_RX_NINE];
        st_nxt.single_word_receive_enable = avs_writedata[`SSR_RX_SINGLE];
        st_nxt.continuous_receive_enable = avs_writedata[`SSR_RX_CONT];
        st_nxt.address_detect_enable = avs_writedata[`SSR_RX_ADDR_DET];
      end else if (avs_address == `SSR_OFF_TX_STAT) begin
        st_nxt.clock_source_select = avs_writedata[`SSR_TX_CLK_SRC];
        st_nxt.transmit_nine_bit_select = avs_writedata[`SSR_TX_NINE];
        st_nxt.transmit_enable = avs_writedata[`SSR_TX_EN];
        st_nxt.clocked_mode_select = avs_writedata[`SSR_TX_CLOCKED];
        st_nxt.high_baud_select = avs_writedata[`SSR_TX_HIGH_BAUD];
        st_nxt.transmit_ninth_data = avs_writedata[`SSR_TX_NINTH];
      end else if (avs_address == `SSR_OFF_BAUD) begin
        st_nxt.baud_divisor = avs_writedata[7:0];
      end else if (avs_address == `SSR_OFF_TX_HOLD) begin
        st_nxt.transmit_holding = avs_writedata[7:0];
        st_nxt.hold_full = 1'b1;
        st_nxt.transmit_buffer_empty_flag = 1'b0;
      end else if (avs_address == `SSR_OFF_IRQ_EN) begin
        st_nxt.receive_irq_enable = avs_writedata[`SSR_IE_RX];
        st_nxt.transmit_irq_enable = avs_writedata[`SSR_IE_TX];
      end
    end
    if (rd_take && (avs_address == `SSR_OFF_RX_BUF)) begin
      st_nxt.receive_done_flag = 1'b0;
    end
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    st_nxt.ck_s1 = serial_clock_pin_i;
    st_nxt.ck_s2 = st_r.ck_s1;
    st_nxt.ck_s3 = st_r.ck_s2;
    st_nxt.dt_s1 = serial_data_pin_i;
    st_nxt.dt_s2 = st_r.dt_s1;
    ext_fall = st_r.ck_s3 && !st_r.ck_s2;
    // ****************************************************************
    // master shift clock: toggles every divisor+1 cycles, low when idle
    // ****************************************************************
    if (active && st_r.clock_source_select && (st_r.tx_busy || st_r.rx_busy)) begin
      if (st_r.baud_cnt == st_r.baud_divisor) begin
        st_nxt.baud_cnt = 8'h00;
        st_nxt.sck = !st_r.sck;
        term = 1'b1;
      end else begin
        st_nxt.baud_cnt = st_r.baud_cnt + 8'h01;
      end
    end else begin
      st_nxt.baud_cnt = 8'h00;
      st_nxt.sck = 1'b0;
    end
    // slave mode uses only the synchronised external edges
    sck_fall = st_r.clock_source_select ? (term && st_r.sck) : ext_fall;
    // ****************************************************************
    // transmitter
    // ****************************************************************
    if (st_r.tx_busy && sck_fall) begin
      if (st_r.tx_cnt == tx_bits - 4'h1) begin
        st_nxt.tx_busy = 1'b0;
        tx_done = 1'b1;
      end else begin
        st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
        st_nxt.transmit_shift_register = {1'b0, st_r.transmit_shift_register[8:1]};
        st_nxt.dout = st_r.transmit_shift_register[1];
      end
    end
    if (!active || !st_r.transmit_enable) begin
      st_nxt.tx_busy = 1'b0;
    end
    // a write in the same cycle holds the move off by one cycle; the waiting word is overwritten
    tx_load = !st_nxt.tx_busy && st_r.hold_full && st_r.transmit_enable && active &&
      !st_r.rx_busy && !st_r.single_word_receive_enable &&
      !st_r.continuous_receive_enable && !wr_hold;
    if (tx_load) begin
      st_nxt.transmit_shift_register = {st_r.transmit_ninth_data, st_r.transmit_holding};
      st_nxt.tx_busy = 1'b1;
      st_nxt.tx_cnt = 4'h0;
      st_nxt.dout = st_r.transmit_holding[0];
      st_nxt.hold_full = 1'b0;
    end
    if (st_r.transmit_enable && !st_nxt.hold_full && !wr_hold) begin
      st_nxt.transmit_buffer_empty_flag = 1'b1;
    end
    // ****************************************************************
    // master receiver
    // ****************************************************************
    rx_start = active && st_r.clock_source_select && !st_r.rx_busy && !st_r.tx_busy &&
      !tx_load && (st_r.single_word_receive_enable || st_r.continuous_receive_enable);
    if (rx_start) begin
      st_nxt.rx_busy = 1'b1;
      st_nxt.rx_cnt = 4'h0;
    end
    if (st_r.rx_busy && sck_fall) begin
      st_nxt.rx_shift = {st_r.dt_s2, st_r.rx_shift[8:1]};
      if (st_r.rx_cnt == rx_bits - 4'h1) begin
        rx_done = 1'b1;
        st_nxt.rx_cnt = 4'h0;
        if (st_r.receive_done_flag && !(rd_take && (avs_address == `SSR_OFF_RX_BUF))) begin
          st_nxt.overrun_error_flag = 1'b1;
        end else begin
          st_nxt.receive_buffer = st_r.receive_nine_bit_select ? st_nxt.rx_shift[7:0] :
            st_nxt.rx_shift[8:1];
          st_nxt.receive_ninth_data = st_r.receive_nine_bit_select && st_r.dt_s2;
          st_nxt.receive_done_flag = 1'b1;
        end
        if (!st_r.continuous_receive_enable) begin
          st_nxt.single_word_receive_enable = 1'b0;
          st_nxt.rx_busy = 1'b0;
        end
      end else begin
        st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
      end
    end
    if (!active || !st_r.clock_source_select ||
        !(st_nxt.single_word_receive_enable || st_nxt.continuous_receive_enable)) begin
      st_nxt.rx_busy = 1'b0;
    end
    if (!st_nxt.continuous_receive_enable) begin
      st_nxt.overrun_error_flag = 1'b0;
      st_nxt.framing_error_flag = 1'b0;
    end
    // ****************************************************************
    // pins and wake request
    // ****************************************************************
    st_nxt.sck_oe = active && st_nxt.clock_source_select;
    st_nxt.dout_oe = st_nxt.tx_busy;
    st_nxt.irq = (st_nxt.receive_done_flag && st_nxt.receive_irq_enable) ||
      (st_nxt.transmit_buffer_empty_flag && st_nxt.transmit_irq_enable);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.wait_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata = {24'h000000, st_r.rdata};
  assign avs_waitrequest = st_r.wait_r;
  assign serial_clock_pin_o = st_r.sck;
  assign serial_clock_pin_oe = st_r.sck_oe;
  assign serial_data_pin_o = st_r.dout;
  assign serial_data_pin_oe = st_r.dout_oe;
  assign irq_wake = st_r.irq;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_rx_start: assert property (@(posedge clk) disable iff (!rst_b)
    rx_start |=> st_r.rx_busy) else $error("reception did not start");
  a_rx_sample_fall: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r.rx_busy && sck_fall) |=> (st_r.rx_shift[8] == $past(st_r.dt_s2)))
    else $error("data not sampled on falling edge");
  a_single_stops: assert property (@(posedge clk) disable iff (!rst_b)
    (rx_done && !st_r.continuous_receive_enable) |=>
    (!st_r.rx_busy && !st_r.single_word_receive_enable))
    else $error("single word reception kept running");
  a_cont_keeps: assert property (@(posedge clk) disable iff (!rst_b)
    (rx_done && st_r.continuous_receive_enable && !wr_take) |=> st_r.rx_busy)
    else $error("continuous reception stopped");
  // flag and wake request are registered on the same edge
  a_rx_flag_irq: assert property (@(posedge clk) disable iff (!rst_b)
    (rx_done && !st_r.receive_done_flag && st_r.receive_irq_enable && !wr_take)
    |=> (st_r.receive_done_flag && irq_wake)) else $error("receive flag or irq missing");
  a_err_clear: assert property (@(posedge clk) disable iff (!rst_b)
    !st_r.continuous_receive_enable |-> !st_r.overrun_error_flag)
    else $error("error kept without continuous enable");
  a_ninth_bit: assert property (@(posedge clk) disable iff (!rst_b)
    (rx_done && st_r.receive_nine_bit_select && !st_r.receive_done_flag) |=>
    (st_r.receive_ninth_data == $past(st_r.dt_s2))) else $error("ninth bit wrong");
  // same cycle: the enable follows the registered source bit, a write may turn it on later
  a_slave_no_clk: assert property (@(posedge clk) disable iff (!rst_b)
    !st_r.clock_source_select |-> !serial_clock_pin_oe)
    else $error("slave drives the clock");
  a_master_idle_low: assert property (@(posedge clk) disable iff (!rst_b)
    (!st_r.tx_busy && !st_r.rx_busy) |=> !serial_clock_pin_o)
    else $error("clock not idle low");
  a_slave_shift: assert property (@(posedge clk) disable iff (!rst_b)
    (!st_r.clock_source_select && st_r.tx_busy && ext_fall && active && st_r.transmit_enable)
    |=> (st_r.tx_cnt != $past(st_r.tx_cnt)) || !st_r.tx_busy || tx_load)
    else $error("slave shift missed an edge");
  a_tx_start: assert property (@(posedge clk) disable iff (!rst_b)
    tx_load |=> (st_r.tx_busy && !st_r.hold_full && serial_data_pin_oe))
    else $error("holding word not moved");
  a_transmit_buffer_empty_flag_wait: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r.tx_busy && st_r.hold_full) |-> !st_r.transmit_buffer_empty_flag)
    else $error("empty flag set with word waiting");
  a_tx_reload: assert property (@(posedge clk) disable iff (!rst_b)
    (tx_done && st_r.hold_full && !wr_hold && st_r.transmit_enable && !rx_start) |=>
    (st_r.tx_busy && st_r.transmit_buffer_empty_flag)) else $error("reload failed");
  a_half_duplex: assert property (@(posedge clk) disable iff (!rst_b)
    !(st_r.tx_busy && st_r.rx_busy)) else $error("transmit and receive overlap");
  a_transmit_buffer_empty_flag_write: assert property (@(posedge clk) disable iff (!rst_b)
    wr_hold |=> !st_r.transmit_buffer_empty_flag) else $error("write left flag set");
  c_single_word: cover property (@(posedge clk) disable iff (!rst_b)
    rx_done && !st_r.continuous_receive_enable);
  c_back_to_back: cover property (@(posedge clk) disable iff (!rst_b)
    tx_done && st_r.hold_full);
  c_overrun: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(st_r.overrun_error_flag));
  c_slave_tx: cover property (@(posedge clk) disable iff (!rst_b)
    tx_done && !st_r.clock_source_select);
endmodule : ssr_top
`default_nettype wire

// ===== dv/ssr_peer.sv
// far-side peer of the clocked serial port: data source for master reception,
// shift clock source and data sink for slave transmission
// assumes the bench resolves the clock and data lines from the port's enables, the peer driving whenever the port does not
`timescale 1ns/1ps
`default_nettype none
module ssr_peer (
  input wire logic clk,
  input wire logic line_ck,
  input wire logic line_dt,
  output logic ext_ck,
  output logic ext_dt
);
  logic [31:0] stream;
  logic [4:0] idx;
  logic ck_d;
  logic [8:0] got;
  initial begin
    stream = 32'h0;
    idx = 5'h0;
    ck_d = 1'b0;
    got = 9'h0;
    ext_ck = 1'b0;
  end
  // ****************************************************************
  // data source
  // ****************************************************************
  // bit moves on only after a falling edge, so the sampled bit is settled
  always @(posedge clk) begin
    ck_d <= line_ck;
    if (ck_d && !line_ck) begin
      idx <= idx + 5'h1;
    end
  end
  assign ext_dt = stream[idx];
  task automatic load(input logic [31:0] s);
    stream = s;
    idx = 5'h0;
  endtask : load
  // ****************************************************************
  // slave clock
  // ****************************************************************
  // one pulse per bit at 125 ns, low between frames; sampled mid-bit
  task automatic clock_bits();
    for (int i = 0; i < 9; i++) begin
      #62.5 ext_ck = 1'b1;
      got = {line_dt, got[8:1]};
      #62.5 ext_ck = 1'b0;
    end
  endtask : clock_bits
endmodule : ssr_peer
`default_nettype wire

// ===== dv/ssr_top_tb.sv
// self-checking bench of the clocked serial port
// assumes ssr_top, ssr_peer and ssr_defs.svh; Avalon-MM master on clk
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defs.svh"
module ssr_top_tb;
  logic clk, rst_b, avs_read, avs_write, irq_wake;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, ck_o, ck_oe, dt_o, dt_oe, peer_ck, peer_dt;
  wire logic ck_line = ck_oe ? ck_o : peer_ck;
  wire logic dt_line = dt_oe ? dt_o : peer_dt;
  logic [7:0] rd, b, wa, wb;
  logic [8:0] w9;
  logic [23:0] r;
  logic t9;
  int miscompares = 0;
  int samples_checked = 0;
  ssr_top ssr_top_inst (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serial_clock_pin_i(ck_line),
    .serial_clock_pin_o(ck_o), .serial_clock_pin_oe(ck_oe), .serial_data_pin_i(dt_line),
    .serial_data_pin_o(dt_o), .serial_data_pin_oe(dt_oe), .irq_wake(irq_wake));
  ssr_peer ssr_peer_inst (.clk(clk), .line_ck(ck_line), .line_dt(dt_line),
    .ext_ck(peer_ck), .ext_dt(peer_dt));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic end_of_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // request held until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic is_wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= !is_wr;
    avs_write <= is_wr;
    avs_writedata <= {24'h0, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, e);
  endtask : rdchk
  // bounded poll with no compare of its own; it returns quietly if the bit never rose
  task automatic poll(input logic [4:0] a, input logic [7:0] m);
    for (int i = 0; i < 300; i++) begin
      bus(1'b0, a, 8'h00);
      if ((rd & m) != 8'h00) break;
    end
  endtask : poll
  function automatic logic [7:0] reset_val(input int i);
    return (i == 2) ? `SSR_TX_STAT_RESET : 8'h00;
  endfunction : reset_val
  // ****************************************************************
  // clock, reset, watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    void'($urandom(32'h363ad893));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    // reset values, unmapped offset 0x1C reads zero
    for (int i = 0; i < 8; i++) rdchk(5'(i * 4), reset_val(i));
    avs_byteenable <= 4'hE;
    wr(`SSR_OFF_BAUD, 8'h55);
    avs_byteenable <= 4'hF;
    rdchk(`SSR_OFF_BAUD, 8'h00);
    // master single 9-bit word, set-up order kept
    b = 8'($urandom_range(3, 1));
    w9 = 9'($urandom_range(511, 0));
    wr(`SSR_OFF_BAUD, b);
    wr(`SSR_OFF_TX_STAT, 8'h90);
    wr(`SSR_OFF_RX_STAT, 8'h80);
    wr(`SSR_OFF_IRQ_EN, 8'h01);
    wr(`SSR_OFF_RX_STAT, 8'hC0);
    ssr_peer_inst.load({23'h0, w9});
    wr(`SSR_OFF_RX_STAT, 8'hE0);
    chk(ck_oe, 1'b1);
    poll(`SSR_OFF_FLAGS, 8'h01);
    chk(rd[0], 1'b1);
    chk(irq_wake, 1'b1);
    // status first, then the buffer
    rdchk(`SSR_OFF_RX_STAT, {7'h60, w9[8]});
    rdchk(`SSR_OFF_RX_BUF, w9[7:0]);
    rdchk(`SSR_OFF_FLAGS, 8'h00);
    chk(irq_wake, 1'b0);
    @(posedge clk);
    rd = 8'h0;
    repeat (100) @(posedge clk) if (ck_o !== 1'b0) rd = 8'h1;
    chk(rd, 8'h0);
    // both enables: continuous, third word overruns while flag is up
    r = 24'($urandom());
    ssr_peer_inst.load({8'h0, r});
    wr(`SSR_OFF_RX_STAT, 8'hB0);
    poll(`SSR_OFF_FLAGS, 8'h01);
    rdchk(`SSR_OFF_RX_BUF, r[7:0]);
    poll(`SSR_OFF_RX_STAT, 8'h02);
    chk(rd[1], 1'b1);
    // software recovers by clearing the continuous enable
    wr(`SSR_OFF_RX_STAT, 8'h80);
    rdchk(`SSR_OFF_RX_STAT, 8'h80);
    rdchk(`SSR_OFF_RX_BUF, r[15:8]);
    // slave transmission; first blocked by a receive enable
    t9 = 1'($urandom());
    wa = 8'($urandom());
    wb = 8'($urandom());
    // ninth bit loaded before any word
    wr(`SSR_OFF_TX_STAT, {7'h38, t9});
    wr(`SSR_OFF_RX_STAT, 8'h90);
    wr(`SSR_OFF_IRQ_EN, 8'h02);
    wr(`SSR_OFF_TX_HOLD, wa);
    repeat (10) @(posedge clk);
    chk(dt_oe, 1'b0);
    chk(ck_oe, 1'b0);
    // enables cleared, the waiting word starts at once
    wr(`SSR_OFF_RX_STAT, 8'h80);
    wr(`SSR_OFF_TX_HOLD, wb);
    rdchk(`SSR_OFF_FLAGS, 8'h00);
    chk(irq_wake, 1'b0);
    chk(dt_oe, 1'b1);
    ssr_peer_inst.clock_bits();
    chk(ssr_peer_inst.got, {t9, wa});
    repeat (4) @(posedge clk);
    rdchk(`SSR_OFF_FLAGS, 8'h02);
    chk(irq_wake, 1'b1);
    wr(`SSR_OFF_FLAGS, 8'h00);
    rdchk(`SSR_OFF_FLAGS, 8'h02);
    ssr_peer_inst.clock_bits();
    chk(ssr_peer_inst.got, {t9, wb});
    repeat (10) @(posedge clk);
    chk(dt_oe, 1'b0);
    rdchk(`SSR_OFF_TX_STAT, {7'h39, t9});
    end_of_test();
  end
endmodule : ssr_top_tb
`default_nettype wire
